// *** rtl/jlt_link_tx.v ***
// Overview of operation
// - in 8b10b mode each transport octet becomes one 10-bit line character via 8b10b coding
// - frames per multiframe K must lie within ceil(17/F) and min(256, floor(1024/F))
// - local multiframe clock spans F*K characters; sysref resets its phase
// - while sync is low every lane sends continuous K28.5 commas
// - after sync rises, wait for own multiframe edge before starting alignment sequence
// - alignment sequence is four multiframes, each opening K28.0 and closing K28.3
// - second alignment multiframe carries the link configuration octets at octets 2..6 of its frame 0, all five only when F is 7 or more
// - scrambler off: repeated frame-end octet sends K28.7, or K28.3 at multiframe end
// - scrambler on: frame-end 0xfc sends K28.7, multiframe-end 0x7c sends K28.3
// - 64b66b: pack eight octets, scramble the block, prepend a two-bit header
// - header at bits 0..1, octet n at bits 2+8n..9+8n up to 65
// - the 8b10b alignment sequence is never scrambled
// - scrambling is optional in 8b10b and always on in 64b66b
// - the two header bits are always complementary, 01 or 10
`timescale 1ns/1ns
`include "jlt_regs.vh"

module jlt_link_tx (
    input  wire        clock,             // device clock, one octet per edge
    input  wire        nrst,              // asynchronous reset, active low
    input  wire        sysref,            // sysref pin, asynchronous
    input  wire        sync_n,            // receiver sync request pin, active low
    input  wire        mode_64b66b,       // 1 selects 64b66b block coding
    input  wire        randomizer_enable, // 8b10b data scrambling enable
    input  wire [8:0]  cfg_f,             // octets per frame
    input  wire [8:0]  cfg_k,             // frames per multiframe
    input  wire [7:0]  cfg_lane_id,       // lane id sent in alignment sequence when F is 3 or more
    input  wire [7:0]  tx_octet,          // octet from transport layer
    input  wire        sh_bit,            // sync header stream bit for next block
    output wire        octet_ready,       // transport octet taken this edge
    output wire        cfg_error,         // frame size setting out of range
    output wire        lmfc_edge,         // last octet of a multiframe
    output reg  [1:0]  link_state,        // current link state
    output reg  [9:0]  tx_char,           // encoded character, bit 9 sent first
    output reg         char_valid,        // tx_char holds a character
    output reg  [0:65] tx_block,          // 66-bit block, bit 0 sent first
    output reg         block_valid        // one-cycle pulse per new block
);

    // pin synchronisers: sysref and sync_n
    reg  [`JLT_SYNC_DEPTH-1:0] pin_sr [0:1];
    reg  [1:0]                 pin_lvl;
    reg  [1:0]                 pin_lvl_d;
    wire [1:0]                 pin_raw = {sync_n, sysref};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            always @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    pin_sr[gi]    <= {`JLT_SYNC_DEPTH{1'b0}};
                    pin_lvl[gi]   <= 1'b0;
                    pin_lvl_d[gi] <= 1'b0;
                end else begin
                    pin_sr[gi] <= {pin_sr[gi][`JLT_SYNC_DEPTH-2:0], pin_raw[gi]};
                    if (pin_sr[gi][1] == pin_sr[gi][2])
                        pin_lvl[gi] <= pin_sr[gi][2];
                    pin_lvl_d[gi] <= pin_lvl[gi];
                end
            end
        end
    endgenerate

    wire sysref_evt = pin_lvl[0] & ~pin_lvl_d[0];
    wire sync_high  = pin_lvl[1];

    // frame size check
    wire [17:0] fk_prod = cfg_f * cfg_k;
    assign cfg_error = (cfg_f == 9'h000) || (fk_prod < `JLT_FK_MIN) ||
                       (fk_prod > `JLT_FK_MAX) || (cfg_k > `JLT_K_MAX);

    // ones count helpers
    function [2:0] ones6;
        input [5:0] v;
        begin
            ones6 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} +
                    {2'h0, v[3]} + {2'h0, v[4]} + {2'h0, v[5]};
        end
    endfunction

    function [2:0] ones4;
        input [3:0] v;
        begin
            ones4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
        end
    endfunction

    // 8b10b encode: returns {new disparity, abcdei, fghj}
    function [10:0] enc8b10b;
        input [7:0] v;
        input       k;
        input       rd;
        reg   [5:0] c6;
        reg   [3:0] c4;
        reg   [4:0] y;
        reg   [2:0] x;
        reg         rd6;
        reg         alt;
        begin
            y = v[4:0];
            x = v[7:5];
            case (y)
                5'd0:  c6 = 6'b100111;
                5'd1:  c6 = 6'b011101;
                5'd2:  c6 = 6'b101101;
                5'd3:  c6 = 6'b110001;
                5'd4:  c6 = 6'b110101;
                5'd5:  c6 = 6'b101001;
                5'd6:  c6 = 6'b011001;
                5'd7:  c6 = 6'b111000;
                5'd8:  c6 = 6'b111001;
                5'd9:  c6 = 6'b100101;
                5'd10: c6 = 6'b010101;
                5'd11: c6 = 6'b110100;
                5'd12: c6 = 6'b001101;
                5'd13: c6 = 6'b101100;
                5'd14: c6 = 6'b011100;
                5'd15: c6 = 6'b010111;
                5'd16: c6 = 6'b011011;
                5'd17: c6 = 6'b100011;
                5'd18: c6 = 6'b010011;
                5'd19: c6 = 6'b110010;
                5'd20: c6 = 6'b001011;
                5'd21: c6 = 6'b101010;
                5'd22: c6 = 6'b011010;
                5'd23: c6 = 6'b111010;
                5'd24: c6 = 6'b110011;
                5'd25: c6 = 6'b100110;
                5'd26: c6 = 6'b010110;
                5'd27: c6 = 6'b110110;
                5'd28: c6 = 6'b001110;
                5'd29: c6 = 6'b101110;
                5'd30: c6 = 6'b011110;
                default: c6 = 6'b101011;
            endcase
            if (k)
                c6 = 6'b001111;
            // positive disparity takes the complement of unbalanced codes
            if (rd && ((ones6(c6) != 3'd3) || (!k && y == 5'd7)))
                c6 = ~c6;
            rd6 = rd ^ (ones6(c6) != 3'd3);
            alt = (x == 3'd7) && (k || (!rd6 && (y == 5'd17 || y == 5'd18 ||
                  y == 5'd20)) || (rd6 && (y == 5'd11 || y == 5'd13 || y == 5'd14)));
            case (x)
                3'd0:    c4 = 4'b1011;
                3'd1:    c4 = 4'b1001;
                3'd2:    c4 = 4'b0101;
                3'd3:    c4 = 4'b1100;
                3'd4:    c4 = 4'b1101;
                3'd5:    c4 = 4'b1010;
                3'd6:    c4 = 4'b0110;
                default: c4 = alt ? 4'b0111 : 4'b1110;
            endcase
            if (rd6 && ((ones4(c4) != 3'd2) || x == 3'd3))
                c4 = ~c4;
            else if (k && !rd6 && ones4(c4) == 3'd2 && x != 3'd3)
                c4 = ~c4;
            enc8b10b = {rd6 ^ (ones4(c4) != 3'd2), c6, c4};
        end
    endfunction

    // 8b10b scrambler 1 + x^14 + x^15, msb first: returns {state, octet}
    function [22:0] scr8;
        input [7:0]  d;
        input [14:0] s;
        reg   [14:0] st;
        reg   [7:0]  o;
        integer      i;
        begin
            st = s;
            o  = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                o[i] = d[i] ^ st[13] ^ st[14];
                st   = {st[13:0], o[i]};
            end
            scr8 = {st, o};
        end
    endfunction

    // 64b66b scrambler 1 + x^39 + x^58: returns {state, block}
    function [121:0] scr64;
        input [63:0] d;
        input [57:0] s;
        reg   [57:0] st;
        reg   [63:0] o;
        integer      i;
        begin
            st = s;
            o  = 64'h0;
            for (i = 63; i >= 0; i = i - 1) begin
                o[i] = d[i] ^ st[38] ^ st[57];
                st   = {st[56:0], o[i]};
            end
            scr64 = {st, o};
        end
    endfunction

    // local multiframe clock counters
    reg  [8:0] oct_cnt;
    reg  [8:0] frm_cnt;
    wire       frame_last = (oct_cnt == cfg_f - 9'h001);
    assign     lmfc_edge  = frame_last && (frm_cnt == cfg_k - 9'h001);

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oct_cnt <= 9'h000;
            frm_cnt <= 9'h000;
        end else if (sysref_evt) begin
            oct_cnt <= 9'h000;
            frm_cnt <= 9'h000;
        end else if (frame_last) begin
            oct_cnt <= 9'h000;
            frm_cnt <= lmfc_edge ? 9'h000 : frm_cnt + 9'h001;
        end else begin
            oct_cnt <= oct_cnt + 9'h001;
        end
    end

    // link state machine
    reg  [1:0] ilas_mf;
    reg  [1:0] next_state;
    always @* begin
        next_state = link_state;
        case (link_state)
            `JLT_ST_CGS:  if (sync_high && !cfg_error) next_state = `JLT_ST_WAIT;
            `JLT_ST_WAIT: if (lmfc_edge) next_state = `JLT_ST_ILAS;
            `JLT_ST_ILAS: if (lmfc_edge && ilas_mf == `JLT_ILAS_LAST)
                              next_state = `JLT_ST_DATA;
            `JLT_ST_DATA: next_state = `JLT_ST_DATA;
            default:      next_state = `JLT_ST_CGS;
        endcase
        if (!sync_high || cfg_error || mode_64b66b)
            next_state = `JLT_ST_CGS;
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            link_state <= `JLT_ST_CGS;
            ilas_mf    <= 2'h0;
        end else begin
            link_state <= next_state;
            if (link_state != `JLT_ST_ILAS)
                ilas_mf <= 2'h0;
            else if (lmfc_edge)
                ilas_mf <= ilas_mf + 2'h1;
        end
    end

    // configuration octets of the second alignment multiframe
    wire [7:0] cfg_f_m1 = cfg_f[7:0] - 8'h01;
    wire [7:0] cfg_k_m1 = cfg_k[7:0] - 8'h01;
    wire [7:0] cfg_sum  = cfg_lane_id + {randomizer_enable, 7'h00} + cfg_f_m1 + cfg_k_m1;
    reg  [7:0] ilas_oct;
    reg        ilas_k;
    always @* begin
        ilas_k   = 1'b0;
        ilas_oct = oct_cnt[7:0];
        if (oct_cnt == 9'h000 && frm_cnt == 9'h000) begin
            ilas_k   = 1'b1;
            ilas_oct = `JLT_K28_0;
        end else if (lmfc_edge) begin
            ilas_k   = 1'b1;
            ilas_oct = `JLT_K28_3;
        end else if (ilas_mf == `JLT_ILAS_CFG && frm_cnt == 9'h000) begin
            case (oct_cnt)
                9'h001:  begin ilas_k = 1'b1; ilas_oct = `JLT_K28_4; end
                9'h002:  ilas_oct = cfg_lane_id;
                9'h003:  ilas_oct = {randomizer_enable, 7'h00};
                9'h004:  ilas_oct = cfg_f_m1;
                9'h005:  ilas_oct = cfg_k_m1;
                9'h006:  ilas_oct = cfg_sum;
                default: ilas_oct = 8'h00;
            endcase
        end
    end

    // data path: scrambling and alignment character insertion
    reg  [14:0] scr8_st;
    reg  [7:0]  prev_last;
    wire [22:0] scr8_out = scr8(tx_octet, scr8_st);
    wire [7:0]  data_oct = randomizer_enable ? scr8_out[7:0] : tx_octet;
    reg  [7:0]  data_sym;
    reg         data_k;
    always @* begin
        data_sym = data_oct;
        data_k   = 1'b0;
        if (randomizer_enable) begin
            if (lmfc_edge && data_oct == `JLT_K28_3) begin
                data_k = 1'b1;
            end else if (frame_last && data_oct == `JLT_K28_7) begin
                data_k = 1'b1;
            end
        end else if (frame_last && data_oct == prev_last) begin
            data_k   = 1'b1;
            data_sym = lmfc_edge ? `JLT_K28_3 : `JLT_K28_7;
        end
    end

    wire in_data    = (link_state == `JLT_ST_DATA);
    assign octet_ready = mode_64b66b || in_data;

    // choose the character for this edge
    reg  [7:0] sym;
    reg        sym_k;
    always @* begin
        case (link_state)
            `JLT_ST_ILAS: begin sym = ilas_oct; sym_k = ilas_k; end
            `JLT_ST_DATA: begin sym = data_sym; sym_k = data_k; end
            default:      begin sym = `JLT_K28_5; sym_k = 1'b1; end
        endcase
    end

    reg         rd;
    wire [10:0] enc = enc8b10b(sym, sym_k, rd);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd         <= 1'b0;
            tx_char    <= 10'h000;
            char_valid <= 1'b0;
            scr8_st    <= `JLT_SCR8_SEED;
            prev_last  <= 8'h00;
        end else if (mode_64b66b) begin
            char_valid <= 1'b0;
        end else begin
            rd         <= enc[10];
            tx_char    <= enc[9:0];
            char_valid <= 1'b1;
            if (in_data && randomizer_enable)
                scr8_st <= scr8_out[22:8];
            if (in_data && frame_last)
                prev_last <= data_oct;
        end
    end

    // 64b66b block assembly
    reg  [2:0]   blk_cnt;
    reg  [55:0]  blk_acc;
    reg  [57:0]  scr64_st;
    wire [121:0] scr64_out = scr64({blk_acc, tx_octet}, scr64_st);
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            blk_cnt     <= 3'h0;
            blk_acc     <= 56'h0;
            scr64_st    <= `JLT_SCR64_SEED;
            tx_block    <= 66'h0;
            block_valid <= 1'b0;
        end else begin
            block_valid <= 1'b0;
            if (!mode_64b66b || sysref_evt) begin
                blk_cnt <= 3'h0;
            end else if (blk_cnt == `JLT_BLK_LAST) begin
                blk_cnt          <= 3'h0;
                scr64_st         <= scr64_out[121:64];
                tx_block[0:1]    <= sh_bit ? `JLT_SH_ONE : `JLT_SH_ZERO;
                tx_block[2:65]   <= scr64_out[63:0];
                block_valid      <= 1'b1;
            end else begin
                blk_cnt <= blk_cnt + 3'h1;
                blk_acc <= {blk_acc[47:0], tx_octet};
            end
        end
    end

endmodule

// *** rtl/jlt_regs.vh ***
`ifndef JLT_REGS_VH
`define JLT_REGS_VH

// control characters, as pre-coding octets
`define JLT_K28_0        8'h1c
`define JLT_K28_3        8'h7c
`define JLT_K28_4        8'h9c
`define JLT_K28_5        8'hbc
`define JLT_K28_7        8'hfc

// frame size limits
`define JLT_FK_MIN       18'h00011
`define JLT_FK_MAX       18'h00400
`define JLT_K_MAX        9'h100

// link states
`define JLT_ST_CGS       2'h0
`define JLT_ST_WAIT      2'h1
`define JLT_ST_ILAS      2'h2
`define JLT_ST_DATA      2'h3

// alignment sequence length in multiframes, minus one
`define JLT_ILAS_LAST    2'h3
// multiframe that carries the configuration
`define JLT_ILAS_CFG     2'h1

// scrambler seeds
`define JLT_SCR8_SEED    15'h7f80
`define JLT_SCR64_SEED   58'h3ff_ffff_ffff_ffff

// sync header values, bit 0 first
`define JLT_SH_ONE       2'h1
`define JLT_SH_ZERO      2'h2

// octets per 64b66b block, minus one
`define JLT_BLK_LAST     3'h7

// pin synchroniser depth
`define JLT_SYNC_DEPTH   3

`endif

// *** tb/jlt_link_tx_sva.sv ***
`timescale 1ns/1ns
`include "jlt_regs.vh"
module jlt_link_tx_sva (
    input wire logic        clock,       // device clock
    input wire logic        nrst,        // reset, active low
    input wire logic        sysref,      // sysref pin
    input wire logic        sync_n,      // sync request, active low
    input wire logic        mode_64b66b, // block mode
    input wire logic [8:0]  cfg_f,       // octets per frame
    input wire logic [8:0]  cfg_k,       // frames per multiframe
    input wire logic        cfg_error,   // bad frame setting
    input wire logic        lmfc_edge,   // multiframe end
    input wire logic [1:0]  link_state,  // link state
    input wire logic [9:0]  tx_char,     // character out
    input wire logic        char_valid,  // character qualifier
    input wire logic [0:65] tx_block,    // block out
    input wire logic        block_valid  // block pulse
);
    logic [17:0] since_edge; // cycles since multiframe end
    logic        armed;      // an undisturbed multiframe end was seen
    logic [19:0] ilas_len;   // cycles spent in the sequence
    wire  [19:0] mf_len = 20'(cfg_f) * 20'(cfg_k);

    function automatic logic is_k(input logic [9:0] c, input logic [3:0] lo);
        return c == {6'h0f, lo} || c == {6'h30, ~lo};
    endfunction

    // period and sequence length counters
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            since_edge <= 18'h0;
            armed      <= 1'b0;
            ilas_len   <= 20'h0;
        end else begin
            since_edge <= lmfc_edge ? 18'h0 : since_edge + 18'h1;
            armed      <= !(sysref || cfg_error || mode_64b66b) && (lmfc_edge || armed);
            ilas_len   <= (link_state == `JLT_ST_ILAS) ? ilas_len + 20'h1 : 20'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_mf_start;
        lmfc_edge ##1 link_state == `JLT_ST_ILAS;
    endsequence

    a_lmfc_period: assert property (lmfc_edge && armed && !sysref && !cfg_error
        |-> since_edge == 18'(mf_len - 20'h1)) else $error("multiframe period wrong");
    a_cgs_comma: assert property (link_state == `JLT_ST_CGS && !mode_64b66b
        |=> !char_valid || is_k(tx_char, 4'ha)) else $error("no comma in sync state");
    a_sync_cgs: assert property ((!sync_n) [*8]
        |-> link_state == `JLT_ST_CGS) else $error("sync low left unanswered");
    a_hold_off: assert property (link_state == `JLT_ST_WAIT && !lmfc_edge
        |=> link_state != `JLT_ST_ILAS) else $error("sequence started off edge");
    a_ilas_start: assert property (link_state == `JLT_ST_WAIT && lmfc_edge && sync_n
        && !cfg_error |=> link_state == `JLT_ST_ILAS) else $error("sequence not started");
    a_ilas_open: assert property (s_mf_start
        |=> is_k(tx_char, 4'h4)) else $error("multiframe start char wrong");
    a_ilas_close: assert property (lmfc_edge && link_state == `JLT_ST_ILAS
        |=> is_k(tx_char, 4'h3)) else $error("multiframe end char wrong");
    a_ilas_length: assert property (link_state == `JLT_ST_DATA
        && $past(link_state) == `JLT_ST_ILAS |-> ilas_len == 20'(mf_len * 4))
        else $error("sequence length wrong");
    a_cfg_refuse: assert property (cfg_error |=> link_state == `JLT_ST_CGS)
        else $error("bad setting left sync state");
    a_block_gap: assert property (block_valid
        |=> (!block_valid) [*7] ##1 block_valid) else $error("block spacing wrong");
    a_header_comp: assert property (block_valid |-> tx_block[0] != tx_block[1])
        else $error("header bits equal");
endmodule

bind jlt_link_tx jlt_link_tx_sva i_jlt_link_tx_sva (.clock, .nrst, .sysref, .sync_n,
    .mode_64b66b, .cfg_f, .cfg_k, .cfg_error, .lmfc_edge, .link_state, .tx_char,
    .char_valid, .tx_block, .block_valid);

// *** tb/jlt_rx_model.sv ***
`timescale 1ns/1ns
module jlt_rx_model (
    input  wire logic       clock,      // device clock
    input  wire logic       nrst,       // reset, active low
    input  wire logic       sysref,     // shared sysref
    input  wire logic       restart_n,  // low asks for a resync
    input  wire logic [8:0] cfg_f,      // octets per frame
    input  wire logic [8:0] cfg_k,      // frames per multiframe
    input  wire logic [9:0] tx_char,    // received character
    input  wire logic       char_valid, // character qualifier
    output logic            sync_n      // sync request, active low
);
    logic [17:0] mf_cnt;   // own multiframe position
    logic [2:0]  commas;   // consecutive comma count
    logic        sysref_q; // sysref edge detect
    wire         comma = char_valid && (tx_char == 10'h0fa || tx_char == 10'h305);
    wire  [17:0] mf_last = 18'(cfg_f) * 18'(cfg_k) - 18'h1;

    // own multiframe clock, comma lock and sync release
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mf_cnt   <= 18'h0;
            commas   <= 3'h0;
            sysref_q <= 1'b0;
            sync_n   <= 1'b0;
        end else begin
            sysref_q <= sysref;
            if (sysref && !sysref_q)
                mf_cnt <= 18'h0;
            else if (mf_cnt >= mf_last)
                mf_cnt <= 18'h0;
            else
                mf_cnt <= mf_cnt + 18'h1;
            if (!restart_n || (!sync_n && !comma))
                commas <= 3'h0;
            else if (commas != 3'h4)
                commas <= commas + 3'h1;
            if (!restart_n)
                sync_n <= 1'b0;
            else if (commas == 3'h4 && mf_cnt >= mf_last)
                sync_n <= 1'b1;
        end
    end
endmodule

// *** tb/jlt_link_tx_bench.sv ***
`timescale 1ns/1ns
`include "jlt_regs.vh"
module jlt_link_tx_bench;
    logic        clock;                     // device clock
    logic        nrst              = 1'b0;  // reset, active low
    logic        sysref            = 1'b0;  // sysref pin
    logic        restart_n         = 1'b0;  // resync request to the receiver
    logic        mode_64b66b       = 1'b0;  // block mode
    logic        randomizer_enable = 1'b0;  // scrambling
    logic [8:0]  cfg_f             = 9'h002; // octets per frame
    logic [8:0]  cfg_k             = 9'h009; // frames per multiframe
    logic [7:0]  tx_octet          = 8'h55; // transport octet
    logic        sh_bit            = 1'b0;  // header bit
    wire         sync_n;                    // from receiver model
    wire         octet_ready;               // octet taken
    wire         cfg_error;                 // bad setting
    wire         lmfc_edge;                 // multiframe end
    wire  [1:0]  link_state;                // link state
    wire  [9:0]  tx_char;                   // character out
    wire         char_valid;                // character qualifier
    wire  [0:65] tx_block;                  // block out
    wire         block_valid;               // block pulse
    int          mismatches;                // failed comparisons
    int          n_checks;                  // comparisons made

    jlt_link_tx i_jlt_link_tx (.clock, .nrst, .sysref, .sync_n, .mode_64b66b,
        .randomizer_enable, .cfg_f, .cfg_k, .cfg_lane_id(8'h05), .tx_octet, .sh_bit,
        .octet_ready, .cfg_error, .lmfc_edge, .link_state, .tx_char, .char_valid,
        .tx_block, .block_valid);
    jlt_rx_model i_jlt_rx_model (.clock, .nrst, .sysref, .restart_n, .cfg_f, .cfg_k,
        .tx_char, .char_valid, .sync_n);

    // expected control character, disparity variant taken from what was seen
    function automatic logic [9:0] kx(input logic [9:0] got, input logic [3:0] lo);
        return (got[9:4] == 6'h30) ? {6'h30, ~lo} : {6'h0f, lo};
    endfunction

    task automatic check_char(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t char %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic t_reset_comma();
        @(posedge clock);
        @(negedge clock);
        check_flag(char_valid, 1'b1);
        check_char(tx_char, 10'h0fa);
        @(negedge clock);
        check_char(tx_char, 10'h305);
        $display("reset comma done");
    endtask

    task automatic t_cfg_range();
        int tab [8][3] = '{'{2, 8, 1}, '{2, 9, 0}, '{3, 5, 1}, '{3, 6, 0},
                           '{4, 256, 0}, '{4, 257, 1}, '{8, 128, 0}, '{8, 129, 1}};
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            cfg_f <= 9'(tab[i][0]);
            cfg_k <= 9'(tab[i][1]);
            @(negedge clock);
            check_flag(cfg_error, tab[i][2] != 0);
        end
        @(posedge clock);
        cfg_f <= 9'h002;
        cfg_k <= 9'h009;
        $display("frame size range done");
    endtask

    // waits for the sequence and checks its four multiframes
    task automatic run_ilas();
        int w = 0;
        while (link_state !== `JLT_ST_ILAS && w < 400) begin
            @(negedge clock);
            w++;
        end
        check_flag(link_state == `JLT_ST_ILAS, 1'b1);
        for (int i = 0; i < 72; i++) begin
            @(negedge clock);
            if (i % 18 == 0)
                check_char(tx_char, kx(tx_char, 4'h4));
            else if (i % 18 == 17)
                check_char(tx_char, kx(tx_char, 4'h3));
            else if (i == 19)
                check_char(tx_char, kx(tx_char, 4'h2));
        end
        check_flag(link_state == `JLT_ST_DATA, 1'b1);
    endtask

    task automatic t_align();
        @(posedge clock);
        sysref <= 1'b1;
        repeat (6) @(posedge clock);
        sysref    <= 1'b0;
        restart_n <= 1'b1;
        run_ilas();
        for (int j = 0; j < 36; j++) begin
            @(negedge clock);
            if (j % 18 == 17)
                check_char(tx_char, kx(tx_char, 4'h3));
            else if (j % 2 == 1 && j > 1)
                check_char(tx_char, kx(tx_char, 4'h8));
            else
                check_char(tx_char, 10'h2a5);
        end
        $display("alignment and plain data done");
    endtask

    task automatic t_restart();
        int plain = 0;
        @(posedge clock);
        restart_n         <= 1'b0;
        sysref            <= 1'b1;
        randomizer_enable <= 1'b1;
        repeat (6) @(posedge clock);
        sysref <= 1'b0;
        @(negedge clock);
        check_flag(link_state == `JLT_ST_CGS, 1'b1);
        // the first comma leaves the encoder one edge after the state change
        @(negedge clock);
        check_char(tx_char, kx(tx_char, 4'ha));
        @(posedge clock);
        restart_n <= 1'b1;
        run_ilas();
        for (int j = 0; j < 36; j++) begin
            @(negedge clock);
            if (tx_char == 10'h2a5)
                plain++;
            if (tx_char[9:4] == 6'h0f || tx_char[9:4] == 6'h30)
                check_flag(j % 2 == 1 && (tx_char == kx(tx_char, 4'h8) ||
                    (j % 18 == 17 && tx_char == kx(tx_char, 4'h3))), 1'b1);
        end
        check_flag(plain < 18, 1'b1);
        $display("restart and scrambled data done");
    endtask

    task automatic t_blocks();
        logic [0:65]  b1;
        logic [0:65]  b2;
        logic [0:127] s;
        logic [7:0]   pat = 8'ha5;
        int           bad = 0;
        int           w;
        @(posedge clock);
        mode_64b66b <= 1'b1;
        tx_octet    <= 8'ha5;
        sh_bit      <= 1'b1;
        for (int n = 0; n < 3; n++) begin
            w = 0;
            do begin
                @(negedge clock);
                w++;
            end while (block_valid !== 1'b1 && w < 20);
            b1 = b2;
            b2 = tx_block;
        end
        s = {b1[2:65], b2[2:65]};
        for (int j = 64; j < 128; j++)
            if ((s[j] ^ s[j - 39] ^ s[j - 58]) !== pat[7 - j % 8])
                bad++;
        check_flag(bad == 0, 1'b1);
        check_flag(b1[0:1] == 2'h1 && b2[0:1] == 2'h1, 1'b1);
        $display("block coding done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // free running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // watchdog against a hung run
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_reset_comma();
        t_cfg_range();
        t_align();
        t_restart();
        t_blocks();
        give_verdict();
    end
endmodule
